// ### hw/isr_pkg.sv
// Package for the instrument status reporting block.
// Assumes one instrument clock; commands arrive already decoded as strobes.
package isr_pkg;
   localparam int          REG_W        = 8;
   localparam logic [7:0]  ZERO_BYTE    = 8'h00;
   // Standard event bit positions
   localparam int          SE_PWR_ON    = 7;
   localparam int          SE_CMD_ERR   = 5;
   localparam int          SE_EXEC_ERR  = 4;
   localparam int          SE_QUERY_ERR = 2;
   localparam int          SE_OP_DONE   = 0;
   // Operation event bit positions
   localparam int          OP_LINK_FLT  = 7;
   localparam int          OP_TRIM_FLT  = 6;
   localparam int          OP_FRESH     = 4;
   localparam int          OP_SLEW1     = 3;
   localparam int          OP_SLEW2     = 2;
   localparam int          OP_OVR_A     = 1;
   localparam int          OP_OVR_B     = 0;
   // Status byte layout
   localparam int          SB_OP_SUM    = 7;
   localparam int          SB_RQS       = 6;
   localparam int          SB_STD_SUM   = 5;
   localparam int          SB_MSG_AVAIL = 4;
   // Query selector for the response port
   typedef enum logic [2:0]
   {
      ISR_Q_ESR,
      ISR_Q_ESE,
      ISR_Q_SRE,
      ISR_Q_STB,
      ISR_Q_OPEV,
      ISR_Q_OPEN,
      ISR_Q_OPCOND
   } isr_query_e;
endpackage

// ### hw/isr_event_if.sv
// Carrier between the top and the event latch module.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface isr_event_if #(parameter int W = 8);
   logic [W-1:0] set_bits;
   logic         clear;
   logic [W-1:0] enable;
   logic [W-1:0] latched;
   logic         summary;
   modport latch (input set_bits, input clear, input enable,
                  output latched, output summary);
   modport user  (output set_bits, output clear, output enable,
                  input latched, input summary);
endinterface
`default_nettype wire

// ### hw/isr_event_latch.sv
// Event register with enable masking and summary output.
// Assumes clear is a one-cycle strobe in the clock domain.
`timescale 1ns/1ps
`default_nettype none
module isr_event_latch #(
   parameter int W = 8
) (
   input  wire logic   clock,
   input  wire logic   sys_rst,
   isr_event_if.latch  ev
);
   logic [W-1:0] event_reg;
   logic [W-1:0] event_next;
   logic [W-1:0] masked;

   // sticky events
   // Set wins over the clear so an event in the clearing cycle survives
   assign event_next = ev.clear ? ev.set_bits : (event_reg | ev.set_bits);
   assign masked     = event_reg & ev.enable;
   assign ev.summary = |masked;
   assign ev.latched = event_reg;

   always_ff @(posedge clock)
   begin
      if (sys_rst)
         event_reg <= '0;
      else
         event_reg <= event_next;
   end

   // A bit may only fall in the cycle after a clear strobe
   held_bit_a: assert property (@(posedge clock) disable iff (sys_rst)
      $past(!sys_rst && !ev.clear)
         |-> (($past(event_reg) & ~event_reg) == '0))
      else $error("latched event bit dropped without clear");
   clr_zero_a: assert property (@(posedge clock) disable iff (sys_rst)
      (ev.clear && ev.set_bits == '0) |=> event_reg == '0)
      else $error("event register not cleared");
   sum_track_a: assert property (@(posedge clock) disable iff (sys_rst)
      ev.summary == |(event_reg & ev.enable))
      else $error("summary does not follow masked events");
endmodule
`default_nettype wire

// ### hw/isr_status_top.sv
// Status reporting core: standard and operation event sets, status byte,
// service request enable and request line.
// Assumes a command decoder delivers one-cycle strobes and write data.
//
// Summary of operation
// - Operation condition register shows live status, never latched or cleared.
// - Querying an event register returns it then clears it.
// - Clear-status command clears both event registers together.
// - Power-on reset clears event, enable registers and status byte except message-available.
// - Enable registers survive reads; writing zero clears them.
// - No direct status byte clear; summaries fall with their event registers.
// - Reading standard events clears event summary bit five.
// - Standard event bit seven marks a power-up.
// - Standard event bit five marks a command error.
// - Standard event bit four marks an execution error.
// - Standard event bit two marks lost response data.
// - After operation-complete command, bit zero sets when operations finish.
// - Standard enable register written and read; masks the event summary.
// - Operation event bit seven marks a processor link fault.
// - Operation event bit six marks bad trim data.
// - Operation event bit four marks a fresh sample.
// - Operation bits three and two mark loop slew completions.
// - Operation bits one and zero mark input overrange.
// - Operation mask write and read, event read-clear, condition read.
// - Status byte holds both summaries and message-available.
// - Service request only from summaries enabled in request enable.
// - Latched event ignores repeats until cleared.
// - Event AND enable, ORed, forms each set's summary.
// - Operation summary bit 7, event summary 5, message-available 4.
// - Bit 6 request in a poll, master summary in a query; serial poll clears request, not master summary.
`timescale 1ns/1ps
`default_nettype none
module isr_status_top #(
   parameter int W = 8
) (
   input  wire logic                   clock,
   input  wire logic                   sys_rst,
   // Event sources
   input  wire logic                   cmd_error,
   input  wire logic                   exec_error,
   input  wire logic                   query_lost,
   input  wire logic                   ops_pending,
   input  wire logic                   link_fault,
   input  wire logic                   trim_fault,
   input  wire logic                   fresh_sample_flag,
   input  wire logic                   loop_one_slew_done,
   input  wire logic                   loop_two_slew_done,
   input  wire logic                   input_a_overrange,
   input  wire logic                   input_b_overrange,
   input  wire logic                   msg_available,
   // Decoded commands
   input  wire logic                   clear_status_cmd,
   input  wire logic                   op_complete_cmd,
   input  wire logic                   std_mask_wr,
   input  wire logic                   op_event_mask_cmd,
   input  wire logic                   srq_mask_wr,
   input  wire logic [W-1:0]           wr_data,
   input  wire logic                   query_stb,
   input  wire isr_pkg::isr_query_e    query_sel,
   input  wire logic                   serial_poll,
   // Answers
   output logic [W-1:0]                query_data,
   output logic                        query_valid,
   output logic [W-1:0]                poll_data,
   output logic                        poll_valid,
   output logic                        service_request
);
   isr_event_if #(.W(W)) std_if ();
   isr_event_if #(.W(W)) op_if ();

   logic [W-1:0] std_en_reg;
   logic [W-1:0] op_en_reg;
   logic [W-1:0] srq_en_reg;
   logic         opc_armed_reg;
   logic         opc_armed_next;
   logic         pwr_flag_reg;
   logic         rqs_reg;
   logic         rqs_next;
   logic         mss_prev_reg;
   logic [W-1:0] query_data_reg;
   logic         query_valid_reg;
   logic [W-1:0] poll_data_reg;
   logic         poll_valid_reg;

   logic [W-1:0] std_set;
   logic [W-1:0] op_cond;
   logic [W-1:0] sum_byte;
   logic [W-1:0] stb_value;
   logic         mss;
   logic         opc_fire;
   logic         rd_std;
   logic         rd_op;
   logic [W-1:0] query_mux;

   assign op_cond = W'({link_fault, trim_fault, 1'b0, fresh_sample_flag,
                         loop_one_slew_done, loop_two_slew_done,
                         input_a_overrange, input_b_overrange});

   assign opc_fire       = opc_armed_reg && !ops_pending;
   assign opc_armed_next = op_complete_cmd | (opc_armed_reg & ~opc_fire);

   always_comb
   begin
      std_set                       = '0;
      std_set[isr_pkg::SE_PWR_ON]   = pwr_flag_reg;
      std_set[isr_pkg::SE_CMD_ERR]  = cmd_error;
      std_set[isr_pkg::SE_EXEC_ERR] = exec_error;
      std_set[isr_pkg::SE_QUERY_ERR]= query_lost;
      std_set[isr_pkg::SE_OP_DONE]  = opc_fire;
   end

   assign rd_std = query_stb && query_sel == isr_pkg::ISR_Q_ESR;
   assign rd_op  = query_stb && query_sel == isr_pkg::ISR_Q_OPEV;

   assign std_if.set_bits = std_set;
   assign std_if.clear    = rd_std | clear_status_cmd;
   assign std_if.enable   = std_en_reg;
   assign op_if.set_bits  = op_cond;
   assign op_if.clear     = rd_op | clear_status_cmd;
   assign op_if.enable    = op_en_reg;

   isr_event_latch #(.W(W)) u_std_latch
   (
      .clock   (clock),
      .sys_rst (sys_rst),
      .ev      (std_if.latch)
   );

   isr_event_latch #(.W(W)) u_op_latch
   (
      .clock   (clock),
      .sys_rst (sys_rst),
      .ev      (op_if.latch)
   );

   always_comb
   begin
      sum_byte                         = '0;
      sum_byte[isr_pkg::SB_OP_SUM]     = op_if.summary;
      sum_byte[isr_pkg::SB_STD_SUM]    = std_if.summary;
      sum_byte[isr_pkg::SB_MSG_AVAIL]  = msg_available;
   end

   // master summary from enabled summaries only
   assign mss = |(sum_byte & srq_en_reg);

   // request sets on a rising master summary, poll clears it
   assign rqs_next = !mss ? 1'b0 :
                     serial_poll ? 1'b0 :
                     (mss && !mss_prev_reg) ? 1'b1 : rqs_reg;

   always_comb
   begin
      stb_value                  = sum_byte;
      stb_value[isr_pkg::SB_RQS] = mss;
   end

   // query answers; reads leave enables intact
   always_comb
   begin
      case (query_sel)
         isr_pkg::ISR_Q_ESR:    query_mux = std_if.latched;
         isr_pkg::ISR_Q_ESE:    query_mux = std_en_reg;
         isr_pkg::ISR_Q_SRE:    query_mux = srq_en_reg;
         isr_pkg::ISR_Q_STB:    query_mux = stb_value;
         isr_pkg::ISR_Q_OPEV:   query_mux = op_if.latched;
         isr_pkg::ISR_Q_OPEN:   query_mux = op_en_reg;
         isr_pkg::ISR_Q_OPCOND: query_mux = op_cond;
         default:               query_mux = '0;
      endcase
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         std_en_reg <= '0;
         op_en_reg  <= '0;
         srq_en_reg <= '0;
      end
      else
      begin
         if (std_mask_wr)
            std_en_reg <= wr_data;
         if (op_event_mask_cmd)
            op_en_reg <= wr_data;
         if (srq_mask_wr)
            srq_en_reg <= wr_data;
      end
   end

   // power-up seen once after reset release
   always_ff @(posedge clock)
   begin
      if (sys_rst)
         pwr_flag_reg <= 1'b1;
      else
         pwr_flag_reg <= 1'b0;
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         opc_armed_reg <= 1'b0;
         rqs_reg       <= 1'b0;
         mss_prev_reg  <= 1'b0;
      end
      else
      begin
         opc_armed_reg <= opc_armed_next;
         rqs_reg       <= rqs_next;
         mss_prev_reg  <= mss;
      end
   end

   // Answer registers: query returns value before the clear lands
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         query_data_reg  <= isr_pkg::ZERO_BYTE;
         query_valid_reg <= 1'b0;
         poll_data_reg   <= isr_pkg::ZERO_BYTE;
         poll_valid_reg  <= 1'b0;
      end
      else
      begin
         query_valid_reg <= query_stb;
         poll_valid_reg  <= serial_poll;
         if (query_stb)
            query_data_reg <= query_mux;
         if (serial_poll)
            poll_data_reg <= {sum_byte[W-1:isr_pkg::SB_RQS+1], rqs_reg,
                              sum_byte[isr_pkg::SB_RQS-1:0]};
      end
   end

   assign query_data      = query_data_reg;
   assign query_valid     = query_valid_reg;
   assign poll_data       = poll_data_reg;
   assign poll_valid      = poll_valid_reg;
   assign service_request = rqs_reg;

   sequence clr_cmd_s;
      clear_status_cmd && std_set == '0 && op_cond == '0;
   endsequence
   sequence both_zero_s;
      std_if.latched == '0 && op_if.latched == '0;
   endsequence

   cls_both_a: assert property (@(posedge clock) disable iff (sys_rst)
      clr_cmd_s |=> both_zero_s)
      else $error("clear status left events set");
   esr_clear_a: assert property (@(posedge clock) disable iff (sys_rst)
      (rd_std && std_set == '0) |=> !std_if.summary
                                 && query_data == $past(std_if.latched))
      else $error("standard read did not clear summary");
   reset_zero_a: assert property (@(posedge clock)
      $past(sys_rst) && !sys_rst |-> std_en_reg == '0 && op_en_reg == '0
                                  && srq_en_reg == '0 && !service_request)
      else $error("enable registers not cleared at reset");
   mask_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
      (query_stb && !std_mask_wr) |=> std_en_reg == $past(std_en_reg))
      else $error("query disturbed enable register");
   srq_gate_a: assert property (@(posedge clock) disable iff (sys_rst)
      service_request |-> $past(|(sum_byte & srq_en_reg)))
      else $error("request raised without enabled summary");
   poll_clear_a: assert property (@(posedge clock) disable iff (sys_rst)
      (serial_poll && mss) |=> !rqs_reg ##0 (mss || !$past(mss)))
      else $error("serial poll did not clear request");
   opc_set_a: assert property (@(posedge clock) disable iff (sys_rst)
      (opc_armed_reg && !ops_pending && !std_if.clear)
         |=> std_if.latched[isr_pkg::SE_OP_DONE])
      else $error("operation complete bit not set");
   cond_live_a: assert property (@(posedge clock) disable iff (sys_rst)
      (query_stb && query_sel == isr_pkg::ISR_Q_OPCOND)
         |=> query_data == $past(op_cond))
      else $error("condition read not live");
   layout_a: assert property (@(posedge clock) disable iff (sys_rst)
      stb_value[isr_pkg::SB_STD_SUM] == std_if.summary
      && stb_value[isr_pkg::SB_OP_SUM] == op_if.summary
      && stb_value[isr_pkg::SB_MSG_AVAIL] == msg_available)
      else $error("status byte layout wrong");

   sequence mss_rise_s;
      mss && !mss_prev_reg && !serial_poll;
   endsequence
   pwr_flag_a: assert property (@(posedge clock) disable iff (sys_rst)
      $fell(sys_rst) |=> std_if.latched[isr_pkg::SE_PWR_ON])
      else $error("power-on event not flagged");
   cmd_err_a: assert property (@(posedge clock) disable iff (sys_rst)
      cmd_error |=> std_if.latched[isr_pkg::SE_CMD_ERR])
      else $error("command error not latched");
   exec_err_a: assert property (@(posedge clock) disable iff (sys_rst)
      exec_error |=> std_if.latched[isr_pkg::SE_EXEC_ERR])
      else $error("execution error not latched");
   query_err_a: assert property (@(posedge clock) disable iff (sys_rst)
      query_lost |=> std_if.latched[isr_pkg::SE_QUERY_ERR])
      else $error("query error not latched");
   link_flt_a: assert property (@(posedge clock) disable iff (sys_rst)
      link_fault |=> op_if.latched[isr_pkg::OP_LINK_FLT])
      else $error("link fault not latched");
   trim_flt_a: assert property (@(posedge clock) disable iff (sys_rst)
      trim_fault |=> op_if.latched[isr_pkg::OP_TRIM_FLT])
      else $error("trim fault not latched");
   fresh_smp_a: assert property (@(posedge clock) disable iff (sys_rst)
      fresh_sample_flag |=> op_if.latched[isr_pkg::OP_FRESH])
      else $error("fresh sample not latched");
   slew_done_a: assert property (@(posedge clock) disable iff (sys_rst)
      loop_one_slew_done |=> op_if.latched[isr_pkg::OP_SLEW1])
      else $error("loop one slew not latched");
   ovr_set_a: assert property (@(posedge clock) disable iff (sys_rst)
      input_a_overrange |=> op_if.latched[isr_pkg::OP_OVR_A])
      else $error("overrange not latched");
   std_mask_a: assert property (@(posedge clock) disable iff (sys_rst)
      std_mask_wr |=> std_en_reg == $past(wr_data))
      else $error("standard enable write lost");
   op_mask_a: assert property (@(posedge clock) disable iff (sys_rst)
      op_event_mask_cmd |=> op_en_reg == $past(wr_data))
      else $error("operation enable write lost");
   srq_zero_a: assert property (@(posedge clock) disable iff (sys_rst)
      (srq_mask_wr && wr_data == '0) |=> srq_en_reg == '0)
      else $error("request enable not cleared");
   opev_clear_a: assert property (@(posedge clock) disable iff (sys_rst)
      (rd_op && op_cond == '0) |=> op_if.latched == '0
                                 && query_data == $past(op_if.latched))
      else $error("operation read did not clear");
   sum_drop_a: assert property (@(posedge clock) disable iff (sys_rst)
      clr_cmd_s |=> !std_if.summary && !op_if.summary)
      else $error("summary stayed after clear status");
   srq_rise_a: assert property (@(posedge clock) disable iff (sys_rst)
      mss_rise_s |=> service_request)
      else $error("request not raised on summary rise");
endmodule
`default_nettype wire

// ### bench/isr_host_model.sv
// Bus controller model: answers a service request with a serial poll.
// Assumes poll_valid follows the poll strobe within a few cycles.
`timescale 1ns/1ps
`default_nettype none
module isr_host_model (
   input  wire logic       clock,
   input  wire logic       service_request,
   input  wire logic       poll_valid,
   input  wire logic [7:0] poll_data,
   input  wire logic [3:0] lag,
   output var  logic       serial_poll,
   output var  logic [7:0] last_poll,
   output var  int         polls
);
   initial
   begin
      serial_poll = 1'b0;
      last_poll = 8'h00;
      polls = 0;
      forever
      begin
         @(negedge clock);
         if (service_request === 1'b1)
         begin
            // A slow controller leaves the request standing a while
            repeat (lag) @(negedge clock);
            serial_poll = 1'b1;
            @(negedge clock);
            serial_poll = 1'b0;
            for (int i = 0; i < 3 && poll_valid !== 1'b1; i++)
               @(negedge clock);
            last_poll = poll_data;
            polls++;
         end
      end
   end
endmodule
`default_nettype wire

// ### bench/instrument_status_reporting_tb.sv
// Self-checking bench for the status reporting core.
// Assumes the host model polls whenever a service request stands.
`timescale 1ns/1ps
`default_nettype none
module instrument_status_reporting_tb;
   logic                clock, sys_rst, ops_pending, msg_available;
   logic                clear_status_cmd, op_complete_cmd, std_mask_wr;
   logic                op_event_mask_cmd, srq_mask_wr, query_stb;
   logic                query_valid, poll_valid, service_request;
   logic                serial_poll;
   logic [9:0]          ev;
   logic [7:0]          wr_data, query_data, poll_data, last_poll;
   logic [3:0]          lag;
   logic [31:0]         seed;
   isr_pkg::isr_query_e query_sel;
   isr_pkg::isr_query_e msel [3];
   int                  polls, n_errors, checked, ser, oev, ese, ope, sre;
   int                  n;

   isr_status_top #(.W(8)) uut (
      .clock(clock), .sys_rst(sys_rst), .cmd_error(ev[9]),
      .exec_error(ev[8]), .query_lost(ev[7]), .ops_pending(ops_pending),
      .link_fault(ev[6]), .trim_fault(ev[5]), .fresh_sample_flag(ev[4]),
      .loop_one_slew_done(ev[3]), .loop_two_slew_done(ev[2]),
      .input_a_overrange(ev[1]), .input_b_overrange(ev[0]),
      .msg_available(msg_available), .clear_status_cmd(clear_status_cmd),
      .op_complete_cmd(op_complete_cmd), .std_mask_wr(std_mask_wr),
      .op_event_mask_cmd(op_event_mask_cmd), .srq_mask_wr(srq_mask_wr),
      .wr_data(wr_data), .query_stb(query_stb), .query_sel(query_sel),
      .serial_poll(serial_poll), .query_data(query_data),
      .query_valid(query_valid), .poll_data(poll_data),
      .poll_valid(poll_valid), .service_request(service_request));

   isr_host_model host (
      .clock(clock), .service_request(service_request),
      .poll_valid(poll_valid), .poll_data(poll_data), .lag(lag),
      .serial_poll(serial_poll), .last_poll(last_poll), .polls(polls));

   initial
   begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // Expected status byte; bit 6 of the request mask never counts
   function automatic int stb_exp();
      int s;
      s = ((oev & ope) != 0 ? 8'h80 : 0) | ((ser & ese) != 0 ? 8'h20 : 0);
      s = s | (msg_available === 1'b1 ? 8'h10 : 0);
      return s | ((s & sre & 8'hB0) != 0 ? 8'h40 : 0);
   endfunction

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up();
      $display("errors %0d, checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // One-cycle event pulse; the model latches it like the device should
   task automatic pulse(input logic [9:0] m);
      ev = m;
      @(negedge clock);
      ev = '0;
      oev = oev | {m[6:5], 1'b0, m[4:0]};
      ser = ser | {2'b00, m[9:8], 1'b0, m[7], 2'b00};
   endtask

   task automatic query(input isr_pkg::isr_query_e s, input int exp);
      query_sel = s;
      query_stb = 1'b1;
      @(negedge clock);
      query_stb = 1'b0;
      for (int i = 0; i < 3 && query_valid !== 1'b1; i++)
         @(negedge clock);
      check({7'h00, query_valid}, 8'h01);
      check(query_data, exp[7:0]);
      if (s == isr_pkg::ISR_Q_ESR)
         ser = 0;
      if (s == isr_pkg::ISR_Q_OPEV)
         oev = 0;
   endtask

   task automatic wr(input int k, input int d);
      wr_data = d[7:0];
      std_mask_wr = (k == 0);
      op_event_mask_cmd = (k == 1);
      srq_mask_wr = (k == 2);
      @(negedge clock);
      {std_mask_wr, op_event_mask_cmd, srq_mask_wr} = 3'b000;
      if (k == 0)
         ese = d;
      else if (k == 1)
         ope = d;
      else
         sre = d;
   endtask

   initial
   begin
      repeat (20000) @(posedge clock);
      n_errors++;
      wrap_up();
   end

   initial
   begin
      {sys_rst, ev, ops_pending, msg_available, clear_status_cmd} = '1;
      {ev, ops_pending, msg_available, clear_status_cmd} = '0;
      {op_complete_cmd, std_mask_wr, op_event_mask_cmd} = 3'b000;
      {srq_mask_wr, query_stb, wr_data} = '0;
      query_sel = isr_pkg::ISR_Q_ESR;
      msel = '{isr_pkg::ISR_Q_ESE, isr_pkg::ISR_Q_OPEN, isr_pkg::ISR_Q_SRE};
      {n_errors, checked, oev, ese, ope, sre} = '0;
      ser = 8'h80;
      lag = 4'h1;
      seed = 32'hA5093F4E;
      repeat (5) @(negedge clock);
      sys_rst = 1'b0;
      @(negedge clock);
      for (int k = 0; k < 3; k++)
         query(msel[k], 0);
      query(isr_pkg::ISR_Q_STB, 0);
      query(isr_pkg::ISR_Q_ESR, 8'h80);
      // Each standard error event twice: the second occurrence must change nothing
      for (int i = 7; i < 10; i++)
      begin
         pulse(10'h001 << i);
         pulse(10'h001 << i);
         query(isr_pkg::ISR_Q_ESR, ser);
         query(isr_pkg::ISR_Q_ESR, 0);
      end
      for (int i = 0; i < 7; i++)
      begin
         ev = 10'h001 << i;
         query(isr_pkg::ISR_Q_OPCOND, {ev[6:5], 1'b0, ev[4:0]});
         pulse(10'h001 << i);
         query(isr_pkg::ISR_Q_OPCOND, 0);
         query(isr_pkg::ISR_Q_OPEV, oev);
         query(isr_pkg::ISR_Q_OPEV, 0);
      end
      for (int k = 0; k < 3; k++)
      begin
         seed = lfsr(seed);
         wr(k, k == 2 ? seed[7:0] & 8'hBF : seed[7:0]);
         query(msel[k], k == 2 ? seed[7:0] & 8'hBF : seed[7:0]);
         query(msel[k], k == 2 ? seed[7:0] & 8'hBF : seed[7:0]);
         wr(k, 0);
         query(msel[k], 0);
      end
      ops_pending = 1'b1;
      op_complete_cmd = 1'b1;
      @(negedge clock);
      op_complete_cmd = 1'b0;
      repeat (3) @(negedge clock);
      query(isr_pkg::ISR_Q_ESR, 0);
      ops_pending = 1'b0;
      repeat (2) @(negedge clock);
      query(isr_pkg::ISR_Q_ESR, 8'h01);
      wr(0, 8'h20);
      wr(2, 8'h20);
      // Prompt then slow controller
      for (int j = 0; j < 2; j++)
      begin
         lag = j ? 4'h9 : 4'h1;
         n = polls;
         pulse(10'h200);
         for (int i = 0; i < 4 && service_request !== 1'b1; i++)
            @(negedge clock);
         check({7'h00, service_request}, 8'h01);
         for (int i = 0; i < 20 && polls == n; i++)
            @(negedge clock);
         check(last_poll, 8'h60);
         check({7'h00, service_request}, 8'h00);
         query(isr_pkg::ISR_Q_STB, stb_exp());
         query(isr_pkg::ISR_Q_ESR, 8'h20);
         query(isr_pkg::ISR_Q_STB, stb_exp());
      end
      msg_available = 1'b1;
      wr(1, 8'h80);
      pulse(10'h040);
      query(isr_pkg::ISR_Q_STB, stb_exp());
      check({7'h00, service_request}, 8'h00);
      wr(2, 0);
      pulse(10'h3FF);
      clear_status_cmd = 1'b1;
      @(negedge clock);
      clear_status_cmd = 1'b0;
      {ser, oev} = '0;
      query(isr_pkg::ISR_Q_ESR, 0);
      query(isr_pkg::ISR_Q_OPEV, 0);
      query(isr_pkg::ISR_Q_STB, stb_exp());
      // Mid-run reset must drop enables and flag power-on again
      wr(0, 8'hFF);
      wr(1, 8'h0F);
      sys_rst = 1'b1;
      repeat (2) @(negedge clock);
      sys_rst = 1'b0;
      @(negedge clock);
      {ese, ope, sre} = '0;
      ser = 8'h80;
      for (int k = 0; k < 3; k++)
         query(msel[k], 0);
      query(isr_pkg::ISR_Q_STB, stb_exp());
      query(isr_pkg::ISR_Q_ESR, ser);
      wrap_up();
   end
endmodule
`default_nettype wire
